// file: design/ienc_pkg.sv
// Package: register map, reset values and field layout of the encoder counter front end
package ienc_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] IENC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] IENC_OFF_THRESH = 8'h04;
	localparam logic [7:0] IENC_OFF_HYST   = 8'h08;
	localparam logic [7:0] IENC_OFF_STATUS = 8'h0c;
	localparam logic [7:0] IENC_OFF_COUNT  = 8'h10;  // Four words, one per channel
	localparam logic [7:0] IENC_OFF_PERIOD = 8'h20;  // Four words, one per channel

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int IENC_CTRL_START    = 0;  // Write 1: begin a measurement
	localparam int IENC_CTRL_STOP     = 1;  // Write 1: end the measurement
	localparam int IENC_CTRL_NO_INDEX = 2;  // Run without waiting for the index
	localparam int IENC_CTRL_DUAL_A   = 3;  // Channels 1/2 form one dual-track channel
	localparam int IENC_CTRL_DUAL_B   = 4;  // Channels 3/4 form one dual-track channel
	localparam int IENC_CTRL_STYPE    = 5;  // Bits 8:5, channel uses a single-track type

	// ****************************************************************
	// Detector defaults in millivolts
	// ****************************************************************
	localparam logic [15:0] IENC_THRESH_RST_MV = 16'h05dc;  // 1500 mV
	localparam logic [15:0] IENC_HYST_RST_MV   = 16'h01f4;  // 500 mV

	// Index pin idles high when open
	localparam logic IENC_INDEX_IDLE = 1'b1;

	// AHB transfer and response codes
	localparam logic [1:0] IENC_HTRANS_NONSEQ = 2'h2;
	localparam logic       IENC_HRESP_OKAY    = 1'b0;

endpackage : ienc_pkg

// file: design/ienc_det_if.sv
// Interface: threshold settings and sampled levels to the track detectors, states back
`timescale 1ns/1ps
interface ienc_det_if #(
	parameter int N = 4,
	parameter int W = 16
);
	logic [W-1:0]        thresh;
	logic [W-1:0]        hyst;
	logic [N-1:0][W-1:0] level;
	logic [N-1:0]        state;

	modport ctrl (output thresh, output hyst, output level, input state);
	modport det  (input thresh, input hyst, input level, output state);
endinterface : ienc_det_if

// file: design/ienc_detector.sv
// Hysteresis detectors that turn sampled track levels into clean track bits
`timescale 1ns/1ps
module ienc_detector
	import ienc_pkg::*;
#(
	parameter int N = 4,
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Settings and levels in, states out
	ienc_det_if.det  dif
);

	// ****************************************************************
	// Switching points
	// ****************************************************************
	logic signed [W:0] hi_lvl;
	logic signed [W:0] lo_lvl;

	// One extra bit so threshold plus half hysteresis cannot wrap
	always_comb begin
		hi_lvl = (W+1)'($signed(dif.thresh)) + (W+1)'($signed(dif.hyst) >>> 1);
		lo_lvl = (W+1)'($signed(dif.thresh)) - (W+1)'($signed(dif.hyst) >>> 1);
	end

	// ****************************************************************
	// Detector state
	// ****************************************************************
	logic [N-1:0] state_q;

	// Rise above the upper point, fall below the lower point, else hold
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if ((W+1)'($signed(dif.level[i])) > hi_lvl) begin
					state_q[i] <= 1'b1;
				end else if ((W+1)'($signed(dif.level[i])) < lo_lvl) begin
					state_q[i] <= 1'b0;
				end
			end
		end
	end

	assign dif.state = state_q;

	// Checks on channel 0
	property p_det_rise;
		@(posedge clock) disable iff (!rst_n)
		((W+1)'($signed(dif.level[0])) > hi_lvl) |=> state_q[0];
	endproperty
	a_det_rise: assert property (p_det_rise) else $error("detector missed rise");

	property p_det_hold;
		@(posedge clock) disable iff (!rst_n)
		((W+1)'($signed(dif.level[0])) >= lo_lvl && (W+1)'($signed(dif.level[0])) <= hi_lvl)
			|=> state_q[0] == $past(state_q[0]);
	endproperty
	a_det_hold: assert property (p_det_hold) else $error("detector moved in band");

endmodule : ienc_detector

// file: design/ienc_front.sv
// Top: encoder counter front end with AHB-Lite registers, index gating and track decode
//
// Behaviour
// - counters idle until first index rise
// - start trigger state never gates the index
// - index gate rearmed at each measurement start
// - no index: hold reset; index-less: run
// - one index releases all channels together
// - open index idles high, no event
// - dual-track direction from quadrature phase
// - time and frequency from first track only
// - event/frequency/time types force single-track; only the type bits of channels 1 and 3 do so
// - detector switches at threshold plus/minus half hysteresis
// - default threshold 1.5 V, hysteresis 0.5 V
// - four single, two dual, or mixed
// - paired channel of dual shows zero
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ienc_front
	import ienc_pkg::*;
#(
	parameter int CW = 32,  // Counter and period width
	parameter int LW = 16   // Sampled level width, millivolts
) (
	// Clock and reset
	input wire logic                 clock,
	input wire logic                 rst_n,
	// AHB-Lite slave
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic [2:0]           hsize,
	input wire logic [31:0]          hwdata,
	input wire logic                 hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// Conditioned track levels from the converter, same clock
	input wire logic [3:0][LW-1:0]   track_mv,
	// Shared index pin, asynchronous
	input wire logic                 index_pin,
	// Channel results
	output logic [3:0][CW-1:0]       count,
	output logic                     counting
);

	// ****************************************************************
	// Quadrature step: +1, -1 or 0 for one sample pair, {b,a} order
	// ****************************************************************
	function automatic logic [CW-1:0] quad_delta(input logic [1:0] p, input logic [1:0] c);
		logic [1:0] chg;
		chg = p ^ c;
		if (chg == 2'h1 || chg == 2'h2) begin
			quad_delta = (p[1] ^ c[0]) ? CW'(1) : '1;
		end else begin
			quad_delta = '0;
		end
	endfunction : quad_delta

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic        wr_pend_q;
	logic [7:0]  waddr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_word;
	logic        bus_take;

	assign bus_take  = hready && hsel && htrans == IENC_HTRANS_NONSEQ;
	assign hreadyout = 1'b1;             // Zero wait states
	assign hresp     = IENC_HRESP_OKAY;  // Unmapped reads give zero, writes are dropped
	assign hrdata    = hrdata_q;

	// Capture address phase; read data is registered for the data phase
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			waddr_q   <= '0;
			hrdata_q  <= '0;
		end else begin
			wr_pend_q <= bus_take && hwrite;
			if (bus_take) begin
				waddr_q <= haddr[7:0];
				if (!hwrite) begin
					hrdata_q <= rd_word;
				end
			end
		end
	end

	// ****************************************************************
	// Control and settings
	// ****************************************************************
	logic        no_index_q;
	logic        dual_a_q;
	logic        dual_b_q;
	logic [3:0]  stype_q;
	logic [15:0] thresh_q;
	logic [15:0] hyst_q;
	logic        ctrl_wr;
	logic        start_p;
	logic        stop_p;

	assign ctrl_wr = wr_pend_q && waddr_q == IENC_OFF_CTRL;
	assign start_p = ctrl_wr && hwdata[IENC_CTRL_START];
	assign stop_p  = ctrl_wr && hwdata[IENC_CTRL_STOP];

	// Configuration writes; defaults give the documented switching points
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			no_index_q <= 1'b0;
			dual_a_q   <= 1'b0;
			dual_b_q   <= 1'b0;
			stype_q    <= '0;
			thresh_q   <= IENC_THRESH_RST_MV;
			hyst_q     <= IENC_HYST_RST_MV;
		end else if (wr_pend_q) begin
			if (waddr_q == IENC_OFF_CTRL) begin
				no_index_q <= hwdata[IENC_CTRL_NO_INDEX];
				dual_a_q   <= hwdata[IENC_CTRL_DUAL_A];
				dual_b_q   <= hwdata[IENC_CTRL_DUAL_B];
				stype_q    <= hwdata[IENC_CTRL_STYPE +: 4];
			end
			if (waddr_q == IENC_OFF_THRESH) begin
				thresh_q <= hwdata[15:0];
			end
			if (waddr_q == IENC_OFF_HYST) begin
				hyst_q <= hwdata[15:0];
			end
		end
	end

	// A single-track measurement type on the first track of a pair forbids dual use
	logic dual_a_eff;
	logic dual_b_eff;
	assign dual_a_eff = dual_a_q && !stype_q[0];
	assign dual_b_eff = dual_b_q && !stype_q[2];

	// ****************************************************************
	// Track detectors
	// ****************************************************************
	ienc_det_if #(.N(4), .W(LW)) dif ();
	assign dif.thresh = LW'(thresh_q);
	assign dif.hyst   = LW'(hyst_q);
	assign dif.level  = track_mv;

	ienc_detector #(.N(4), .W(LW)) u_det (
		.clock (clock),
		.rst_n (rst_n),
		.dif   (dif.det)
	);

	logic [3:0] trk;
	logic [3:0] trk_prev_q;
	logic [3:0] trk_rise;
	assign trk      = dif.state;
	assign trk_rise = trk & ~trk_prev_q;

	// Previous detector states for edges and quadrature steps
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			trk_prev_q <= '0;
		end else begin
			trk_prev_q <= trk;
		end
	end

	// ****************************************************************
	// Index synchroniser and edge
	// ****************************************************************
	logic idx_s1_q;
	logic idx_s2_q;
	logic idx_prev_q;
	logic idx_rise;

	// Reset to the idle level so a floating pin yields no edge at start-up
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			idx_s1_q   <= IENC_INDEX_IDLE;
			idx_s2_q   <= IENC_INDEX_IDLE;
			idx_prev_q <= IENC_INDEX_IDLE;
		end else begin
			idx_s1_q   <= index_pin;
			idx_s2_q   <= idx_s1_q;
			idx_prev_q <= idx_s2_q;
		end
	end
	assign idx_rise = idx_s2_q && !idx_prev_q;

	// ****************************************************************
	// Measurement run and index gate
	// ****************************************************************
	logic running_q;
	logic gate_q;
	logic cnt_en;

	// Run flag follows start and stop writes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			running_q <= 1'b0;
		end else if (start_p) begin
			running_q <= 1'b1;
		end else if (stop_p) begin
			running_q <= 1'b0;
		end
	end

	// Gate is rearmed at every start; only the index edge or an index-less start opens it, no trigger term
	// The mode bit comes in the same word as START, so it is taken from the bus, not the stale flop
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gate_q <= 1'b0;
		end else if (start_p) begin
			gate_q <= hwdata[IENC_CTRL_NO_INDEX];
		end else if (running_q && idx_rise) begin
			gate_q <= 1'b1;
		end
	end

	assign cnt_en   = running_q && gate_q;
	assign counting = cnt_en;

	// ****************************************************************
	// Channel counters
	// ****************************************************************
	logic [3:0][CW-1:0] cnt_q;
	logic [1:0]         dir_q;

	// Counters held at zero while gated; pairs decode quadrature when dual
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_q <= '0;
			dir_q <= '0;
		end else if (!cnt_en || start_p) begin
			cnt_q <= '0;
		end else begin
			if (dual_a_eff) begin
				cnt_q[0] <= cnt_q[0] + quad_delta(trk_prev_q[1:0], trk[1:0]);
				cnt_q[1] <= '0;
				if (quad_delta(trk_prev_q[1:0], trk[1:0]) != '0) begin
					dir_q[0] <= (trk_prev_q[1] ^ trk[0]);
				end
			end else begin
				cnt_q[0] <= cnt_q[0] + CW'(trk_rise[0]);
				cnt_q[1] <= cnt_q[1] + CW'(trk_rise[1]);
			end
			if (dual_b_eff) begin
				cnt_q[2] <= cnt_q[2] + quad_delta(trk_prev_q[3:2], trk[3:2]);
				cnt_q[3] <= '0;
				if (quad_delta(trk_prev_q[3:2], trk[3:2]) != '0) begin
					dir_q[1] <= (trk_prev_q[3] ^ trk[2]);
				end
			end else begin
				cnt_q[2] <= cnt_q[2] + CW'(trk_rise[2]);
				cnt_q[3] <= cnt_q[3] + CW'(trk_rise[3]);
			end
		end
	end
	assign count = cnt_q;

	// ****************************************************************
	// Period between rising edges, first track of each channel
	// ****************************************************************
	logic [3:0][CW-1:0] tmr_q;
	logic [3:0][CW-1:0] per_q;
	logic [3:0]         per_zero;

	// A second track never drives timing; paired slots stay zero
	assign per_zero = {dual_b_eff, 1'b0, dual_a_eff, 1'b0};

	// Timer saturates rather than wrapping into a false short period
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tmr_q <= '0;
			per_q <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!cnt_en || start_p || per_zero[i]) begin
					tmr_q[i] <= '0;
					per_q[i] <= '0;
				end else if (trk_rise[i]) begin
					per_q[i] <= tmr_q[i];
					tmr_q[i] <= CW'(1);
				end else if (tmr_q[i] != '1) begin
					tmr_q[i] <= tmr_q[i] + CW'(1);
				end
			end
		end
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	always_comb begin
		rd_word = '0;
		case (haddr[7:0])
			IENC_OFF_CTRL: begin
				rd_word[IENC_CTRL_NO_INDEX]    = no_index_q;
				rd_word[IENC_CTRL_DUAL_A]      = dual_a_q;
				rd_word[IENC_CTRL_DUAL_B]      = dual_b_q;
				rd_word[IENC_CTRL_STYPE +: 4]  = stype_q;
			end
			IENC_OFF_THRESH: rd_word[15:0] = thresh_q;
			IENC_OFF_HYST:   rd_word[15:0] = hyst_q;
			IENC_OFF_STATUS: rd_word[9:0]  = {dir_q, trk, idx_s2_q, gate_q, cnt_en, running_q};
			default: begin
				if (haddr[7:4] == IENC_OFF_COUNT[7:4] && haddr[1:0] == 2'h0) begin
					rd_word = 32'(cnt_q[haddr[3:2]]);
				end else if (haddr[7:4] == IENC_OFF_PERIOD[7:4] && haddr[1:0] == 2'h0) begin
					rd_word = 32'(per_q[haddr[3:2]]);
				end
			end
		endcase
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_armed_start;
		start_p && !hwdata[IENC_CTRL_NO_INDEX];
	endsequence

	sequence s_waiting_index;
		running_q && !gate_q && !start_p && !stop_p;
	endsequence

	property p_hold_zero;
		!cnt_en |=> cnt_q == '0;
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("counter moved while gated");

	property p_rearm;
		s_armed_start ##1 (!idx_rise)[*2] |=> !gate_q && cnt_q == '0;
	endproperty
	a_rearm: assert property (p_rearm) else $error("gate open without index");

	property p_index_opens;
		s_waiting_index ##0 idx_rise |=> gate_q && counting;
	endproperty
	a_index_opens: assert property (p_index_opens) else $error("index did not release");

	property p_no_index_runs;
		start_p && hwdata[IENC_CTRL_NO_INDEX] |=> gate_q && running_q;
	endproperty
	a_no_index_runs: assert property (p_no_index_runs) else $error("index-less run blocked");

	property p_reset_no_index_edge;
		$rose(rst_n) |-> !idx_rise [*2];
	endproperty
	a_reset_no_index_edge: assert property (p_reset_no_index_edge) else $error("spurious index");

	property p_pair_zero;
		dual_a_eff |=> cnt_q[1] == '0 && per_q[1] == '0;
	endproperty
	a_pair_zero: assert property (p_pair_zero) else $error("paired channel not zero");

	property p_single_count;
		cnt_en && !start_p && !dual_a_eff && trk_rise[1] |=> cnt_q[1] == $past(cnt_q[1]) + CW'(1);
	endproperty
	a_single_count: assert property (p_single_count) else $error("single-track edge lost");

	property p_quad_dir;
		cnt_en && !start_p && dual_a_eff && trk_prev_q[1:0] == 2'h0 && trk[1:0] == 2'h1
			|=> cnt_q[0] == $past(cnt_q[0]) + CW'(1) && dir_q[0];
	endproperty
	a_quad_dir: assert property (p_quad_dir) else $error("quadrature step wrong");

	property p_period_latch;
		cnt_en && !start_p && trk_rise[0] |=> per_q[0] == $past(tmr_q[0]) && tmr_q[0] == CW'(1);
	endproperty
	a_period_latch: assert property (p_period_latch) else $error("period not latched");

	property p_stype_single;
		cnt_en && !start_p && stype_q[0] && trk_rise[0] |=> cnt_q[0] == $past(cnt_q[0]) + CW'(1);
	endproperty
	a_stype_single: assert property (p_stype_single) else $error("single type in dual");

endmodule : ienc_front

// file: tb/ienc_enc_model.sv
// Stand-in for the encoder sensors: analog track levels and the shared index pin
`timescale 1ns/1ps
module ienc_enc_model
	import ienc_pkg::*;
(
	// Noise from the bench, moves every level inside its band
	input  wire logic [31:0]  noise,
	// Wanted track states; band parks a track between the switch points
	input  wire logic [3:0]   lvl,
	input  wire logic [3:0]   band,
	// Index drive; open leaves the pin to its pull-up
	input  wire logic         idx_drv,
	input  wire logic         idx_open,
	// Sensor outputs
	output logic [3:0][15:0]  track_mv,
	output logic              index_pin
);
	// ****************************************************************
	// Track levels
	// ****************************************************************
	// Band spans 1250..1750 inclusive, so strict compares must hold there
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (band[i])
				track_mv[i] = 16'(32'd1250 + noise % 32'd501);
			else if (lvl[i])
				track_mv[i] = 16'(32'd1751 + noise[9:0]);
			else
				track_mv[i] = 16'(32'd1249 - noise[9:0]);
		end
	end

	// Open pin floats high through the pull-up and never makes an edge
	assign index_pin = idx_open ? IENC_INDEX_IDLE : idx_drv;
endmodule : ienc_enc_model

// file: tb/ienc_front_tb.sv
// Self-checking bench for the encoder counter front end
`timescale 1ns/1ps
module ienc_front_tb
	import ienc_pkg::*;
;
	// ****************************************************************
	// Signals and bench state
	// ****************************************************************
	logic             clock, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic [31:0]      haddr, hwdata, hrdata, rd, seed;
	logic [3:0][15:0] track_mv;
	logic [3:0][31:0] count;
	logic             counting, index_pin, idx_drv, idx_open;
	logic [3:0]       lvl, band;
	int               fail_count, checks_done, gate, ctrl, ph;
	int               exp_c[4];
	// One drive call spans this many cycles: four parked, four at the new level
	localparam int    DRIVE_CYC = 8;

	// Zero-wait slave, so it drives its own ready
	assign hready = hreadyout;

	// 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	ienc_enc_model sensor (
		.noise(seed), .lvl(lvl), .band(band), .idx_drv(idx_drv), .idx_open(idx_open),
		.track_mv(track_mv), .index_pin(index_pin)
	);

	ienc_front dut (
		.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .track_mv(track_mv),
		.index_pin(index_pin), .count(count), .counting(counting)
	);

	// Fixed-seed shift register feeds the sensor noise and random track patterns
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	always @(posedge clock) begin
		seed <= lfsr(seed);
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	// One single AHB transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= IENC_HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		check(32'(hresp), 32'(IENC_HRESP_OKAY));
		check(32'(hreadyout), 32'h1);
	endtask : bus

	// Start a measurement with the given setup; the model restarts from zero
	task automatic cfg(input int v);
		ctrl = v;
		bus(1'b1, IENC_OFF_CTRL, 32'(v) | 32'h1);
		gate = v[IENC_CTRL_NO_INDEX];
		exp_c = '{0, 0, 0, 0};
	endtask : cfg

	function automatic int gray(input int x);
		return (x == 0) ? 0 : (x == 1) ? 1 : (x == 3) ? 2 : 3;
	endfunction : gray

	// Park all tracks in the hysteresis band, then move to new states and compare
	task automatic drive(input logic [3:0] nb);
		int d;
		int a;
		band <= 4'hf;
		repeat (4) @(posedge clock);
		for (int p = 0; p < 2 && gate != 0; p++) begin
			a = 2 * p;
			if (ctrl[IENC_CTRL_DUAL_A + p] && !ctrl[IENC_CTRL_STYPE + a]) begin
				d = (gray({nb[a + 1], nb[a]}) - gray({lvl[a + 1], lvl[a]}) + 4) % 4;
				exp_c[a] += (d == 1) ? 1 : (d == 3) ? -1 : 0;
				exp_c[a + 1] = 0;
			end else begin
				for (int t = a; t < a + 2; t++)
					if (nb[t] && !lvl[t])
						exp_c[t]++;
			end
		end
		lvl  <= nb;
		band <= 4'h0;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 4; i++)
			check(count[i], 32'(exp_c[i]));
		check(32'(counting), 32'(gate));
	endtask : drive

	// Index pin goes low, then rises once; all channels must open together
	task automatic index_rise();
		idx_open <= 1'b0;
		idx_drv  <= 1'b0;
		repeat (4) @(posedge clock);
		idx_drv <= 1'b1;
		repeat (5) @(posedge clock);
		gate = 1;
		check(32'(counting), 32'h1);
	endtask : index_rise

	// Quadrature steps on both pairs at once, A leading B when dn is positive
	task automatic quad(input int n, input int dn);
		logic [1:0] q;
		repeat (n) begin
			ph = (ph + dn + 4) % 4;
			q = 2'(ph ^ (ph >> 1));
			drive({q, q});
		end
	endtask : quad

	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// ****************************************************************
	// Sequence
	// ****************************************************************
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (6000) @(posedge clock);
		fail_count++;
		conclude();
	end

	initial begin
		rst_n    = 1'b0;
		hsel     = 1'b0;
		htrans   = 2'h0;
		haddr    = 32'h0;
		hwrite   = 1'b0;
		hsize    = 3'h2;
		hwdata   = 32'h0;
		seed     = 32'hc6119106;
		lvl      = 4'h0;
		band     = 4'h0;
		idx_drv  = 1'b1;
		idx_open = 1'b1;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		// Detector defaults, then an unmapped place that drops writes
		bus(1'b0, IENC_OFF_THRESH, 32'h0);
		check(rd, 32'(IENC_THRESH_RST_MV));
		bus(1'b0, IENC_OFF_HYST, 32'h0);
		check(rd, 32'(IENC_HYST_RST_MV));
		bus(1'b1, 8'h30, 32'h5a5a);
		bus(1'b0, 8'h30, 32'h0);
		check(rd, 32'h0);
		// Open index keeps the gate shut; one rise frees four single tracks
		cfg(0);
		drive(4'hf);
		drive(4'h0);
		index_rise();
		repeat (12) drive(seed[3:0]);
		// A new start must wait for a new rise; both pairs in quadrature
		cfg((1 << IENC_CTRL_DUAL_A) | (1 << IENC_CTRL_DUAL_B));
		// Let the start write settle before looking at the gate
		@(posedge clock);
		check(32'(counting), 32'h0);
		drive(4'h0);
		index_rise();
		ph = 0;
		quad(9, 1);
		bus(1'b0, IENC_OFF_STATUS, 32'h0);
		check(32'(rd[9:8]), 32'h3);
		// Track A rises every fourth step; paired channel shows zero
		bus(1'b0, IENC_OFF_PERIOD, 32'h0);
		check(rd, 32'(4 * DRIVE_CYC));
		bus(1'b0, IENC_OFF_PERIOD + 8'h4, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, IENC_OFF_COUNT + 8'h4, 32'h0);
		check(rd, 32'h0);
		quad(12, -1);
		bus(1'b0, IENC_OFF_STATUS, 32'h0);
		check(32'(rd[9:8]), 32'h0);
		drive(~lvl);
		// Single type on channel 1 splits the first pair; no index wait
		cfg((1 << IENC_CTRL_DUAL_A) | (1 << IENC_CTRL_STYPE) | (1 << IENC_CTRL_NO_INDEX));
		repeat (6) drive(seed[3:0]);
		// Mixed use: pair A dual, single type on channel 3 splits pair B
		cfg((1 << IENC_CTRL_DUAL_A) | (1 << IENC_CTRL_DUAL_B) | (4 << IENC_CTRL_STYPE) | (1 << IENC_CTRL_NO_INDEX));
		repeat (6) drive(seed[3:0]);
		// Stop holds every counter at zero
		bus(1'b1, IENC_OFF_CTRL, 32'h2);
		gate = 0;
		exp_c = '{0, 0, 0, 0};
		drive(4'hf);
		conclude();
	end
endmodule : ienc_front_tb
